/* File: rtl/twe_eeprom_slave.sv */
// Two-wire slave front end and array control of a 2048 by 8 EEPROM.
`timescale 1ns/1ns
`default_nettype none
`include "twe_map.svh"
module twe_eeprom_slave #(
    parameter int PROG_CYCLES = `TWE_PROG_CYCLES
) (
    // System
    input wire logic clk_sys,
    input wire logic rstn,
    // Two-wire bus pins
    input wire logic sclPin,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOeN,
    // Strap pins
    input wire logic arrayLockPin,
    input wire logic [2:0] unusedChipSelectPins,
    // Status
    output logic progBusy,
    output logic standby
);
    ////////////////////////////////////////////////////////////////////////
    logic [2:0] sclSync_reg;
    logic [2:0] sdaSync_reg;
    logic [2:0] lockSync_reg;
    logic sclLvl_reg;
    logic sdaLvl_reg;
    logic lockLvl_reg;
    twe_pkg::twe_state_t state_reg;
    twe_pkg::twe_state_t ackNext_reg;
    logic [3:0] bitCnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic masterAck_reg;
    logic [2:0] pageBits_reg;
    logic [10:0] addrCnt_reg;
    logic [7:0] pageBuf [16];
    logic [15:0] mask_reg;
    logic [3:0] progIdx_reg;
    logic [`TWE_TIMER_W-1:0] timer_reg;
    logic sdaOeN_reg;
    logic sdaOut_reg;
    logic progBusy_reg;
    logic standby_reg;
    logic [7:0] rdData;
    twe_pkg::twe_memwr_t memWr;
    logic sclRise;
    logic sclFall;
    logic startEv;
    logic stopEv;
    logic rxState;
    logic byteDone;
    logic devMatch;
    logic wordDone;
    logic dataDone;
    logic readLoad;
    logic progStart;
    logic progDone;
    logic busAct;

    assign sdaOut = sdaOut_reg;
    assign sdaOeN = sdaOeN_reg;
    assign progBusy = progBusy_reg;
    assign standby = standby_reg;

    ////////////////////////////////////////////////////////////////////////
    // Pins pass three flops; a level counts once stages two and three agree.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sclSync_reg <= 3'h7;
            sdaSync_reg <= 3'h7;
            lockSync_reg <= 3'h0;
        end else begin
            sclSync_reg <= {sclSync_reg[1:0], sclPin};
            sdaSync_reg <= {sdaSync_reg[1:0], sdaIn};
            lockSync_reg <= {lockSync_reg[1:0], arrayLockPin};
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sclLvl_reg <= 1'b1;
            sdaLvl_reg <= 1'b1;
            lockLvl_reg <= 1'b0;
        end else begin
            if (sclSync_reg[1] == sclSync_reg[2]) begin
                sclLvl_reg <= sclSync_reg[2];
            end
            if (sdaSync_reg[1] == sdaSync_reg[2]) begin
                sdaLvl_reg <= sdaSync_reg[2];
            end
            if (lockSync_reg[1] == lockSync_reg[2]) begin
                lockLvl_reg <= lockSync_reg[2];
            end
        end
    end

    always_comb begin
        sclRise = (sclSync_reg[1] == sclSync_reg[2]) && sclSync_reg[2]
            && !sclLvl_reg;
        sclFall = (sclSync_reg[1] == sclSync_reg[2]) && !sclSync_reg[2]
            && sclLvl_reg;
        busAct = state_reg != twe_pkg::ST_PROG;
        startEv = busAct && sclLvl_reg && !sclFall && sdaLvl_reg
            && (sdaSync_reg[1] == sdaSync_reg[2]) && !sdaSync_reg[2];
        stopEv = busAct && sclLvl_reg && !sclFall && !sdaLvl_reg
            && (sdaSync_reg[1] == sdaSync_reg[2]) && sdaSync_reg[2];
        rxState = state_reg == twe_pkg::ST_DEV
            || state_reg == twe_pkg::ST_WORD
            || state_reg == twe_pkg::ST_DATA;
        byteDone = rxState && sclFall && bitCnt_reg == `TWE_BYTE_BITS;
        devMatch = shift_reg[7:4] == `TWE_DEV_TYPE;
        wordDone = byteDone && state_reg == twe_pkg::ST_WORD;
        dataDone = byteDone && state_reg == twe_pkg::ST_DATA;
        readLoad = sclFall && ((state_reg == twe_pkg::ST_ACK
            && ackNext_reg == twe_pkg::ST_READ)
            || (state_reg == twe_pkg::ST_MACK && masterAck_reg));
        progStart = stopEv && mask_reg != 16'h0000 && !lockLvl_reg;
        progDone = state_reg == twe_pkg::ST_PROG
            && timer_reg == `TWE_TIMER_W'(PROG_CYCLES - 1);
    end

    ////////////////////////////////////////////////////////////////////////
    // Protocol sequencer. The chip-select straps are never read.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_reg <= twe_pkg::ST_IDLE;
            ackNext_reg <= twe_pkg::ST_IDLE;
            bitCnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            masterAck_reg <= 1'b0;
            sdaOeN_reg <= 1'b1;
        end else if (progDone) begin
            state_reg <= twe_pkg::ST_IDLE;
        end else if (startEv) begin
            state_reg <= twe_pkg::ST_DEV;
            bitCnt_reg <= 4'h0;
            sdaOeN_reg <= 1'b1;
        end else if (stopEv) begin
            state_reg <= progStart ? twe_pkg::ST_PROG
                : twe_pkg::ST_IDLE;
            sdaOeN_reg <= 1'b1;
        end else begin
            case (state_reg)
                twe_pkg::ST_DEV, twe_pkg::ST_WORD, twe_pkg::ST_DATA: begin
                    if (sclRise && bitCnt_reg != `TWE_BYTE_BITS) begin
                        shift_reg <= {shift_reg[6:0], sdaLvl_reg};
                        bitCnt_reg <= bitCnt_reg + 4'h1;
                    end else if (byteDone) begin
                        if (state_reg == twe_pkg::ST_DEV && !devMatch) begin
                            state_reg <= twe_pkg::ST_IDLE;
                        end else begin
                            state_reg <= twe_pkg::ST_ACK;
                            sdaOeN_reg <= 1'b0;
                        end
                        if (state_reg != twe_pkg::ST_DEV) begin
                            ackNext_reg <= twe_pkg::ST_DATA;
                        end else if (shift_reg[0]) begin
                            ackNext_reg <= twe_pkg::ST_READ;
                        end else begin
                            ackNext_reg <= twe_pkg::ST_WORD;
                        end
                    end
                end
                twe_pkg::ST_ACK: begin
                    if (sclFall) begin
                        state_reg <= ackNext_reg;
                        bitCnt_reg <= 4'h0;
                        sdaOeN_reg <= 1'b1;
                        if (readLoad) begin
                            tx_reg <= {rdData[6:0], 1'b0};
                            sdaOeN_reg <= rdData[7];
                        end
                    end
                end
                twe_pkg::ST_READ: begin
                    if (sclRise) begin
                        bitCnt_reg <= bitCnt_reg + 4'h1;
                    end else if (sclFall) begin
                        if (bitCnt_reg == `TWE_BYTE_BITS) begin
                            state_reg <= twe_pkg::ST_MACK;
                            sdaOeN_reg <= 1'b1;
                        end else begin
                            tx_reg <= {tx_reg[6:0], 1'b0};
                            sdaOeN_reg <= tx_reg[7];
                        end
                    end
                end
                twe_pkg::ST_MACK: begin
                    if (sclRise) begin
                        masterAck_reg <= !sdaLvl_reg;
                    end else if (sclFall) begin
                        bitCnt_reg <= 4'h0;
                        if (masterAck_reg) begin
                            state_reg <= twe_pkg::ST_READ;
                            tx_reg <= {rdData[6:0], 1'b0};
                            sdaOeN_reg <= rdData[7];
                        end else begin
                            state_reg <= twe_pkg::ST_IDLE;
                        end
                    end
                end
                twe_pkg::ST_PROG: begin
                    sdaOeN_reg <= 1'b1;
                end
                default: begin
                    sdaOeN_reg <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // The address counter has no other reset: it lives as long as power.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            addrCnt_reg <= 11'h000;
            pageBits_reg <= 3'h0;
        end else if (byteDone && state_reg == twe_pkg::ST_DEV) begin
            pageBits_reg <= shift_reg[3:1];
        end else if (wordDone) begin
            addrCnt_reg <= {pageBits_reg, shift_reg};
        end else if (dataDone) begin
            addrCnt_reg <= {addrCnt_reg[10:4],
                addrCnt_reg[3:0] + 4'h1};
        end else if (readLoad) begin
            addrCnt_reg <= addrCnt_reg + 11'h001;
        end
    end

    // Page bytes wait here until STOP, so a write cut short by a START is lost.
    always_ff @(posedge clk_sys) begin
        if (dataDone) begin
            pageBuf[addrCnt_reg[3:0]] <= shift_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mask_reg <= 16'h0000;
        end else if (startEv || progDone || (stopEv && !progStart)) begin
            mask_reg <= 16'h0000;
        end else if (dataDone) begin
            mask_reg[addrCnt_reg[3:0]] <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Programming copies one byte per cycle; the timer keeps the bus deaf.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            timer_reg <= '0;
            progIdx_reg <= 4'h0;
        end else if (state_reg == twe_pkg::ST_PROG) begin
            timer_reg <= timer_reg + `TWE_TIMER_W'(1);
            progIdx_reg <= progIdx_reg + 4'h1;
        end else begin
            timer_reg <= '0;
            progIdx_reg <= 4'h0;
        end
    end

    always_comb begin
        memWr.en = state_reg == twe_pkg::ST_PROG
            && timer_reg < `TWE_TIMER_W'(16) && mask_reg[progIdx_reg];
        memWr.addr = {addrCnt_reg[10:4], progIdx_reg};
        memWr.data = pageBuf[progIdx_reg];
    end

    twe_mem u_mem (
        .clk_sys(clk_sys),
        .memWr(memWr),
        .rdAddr(addrCnt_reg),
        .rdData_reg(rdData)
    );

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sdaOut_reg <= 1'b0;
            progBusy_reg <= 1'b0;
            standby_reg <= 1'b1;
        end else begin
            sdaOut_reg <= 1'b0;
            progBusy_reg <= state_reg == twe_pkg::ST_PROG;
            standby_reg <= state_reg == twe_pkg::ST_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence s_devAck;
        state_reg == twe_pkg::ST_DEV && byteDone && devMatch;
    endsequence
    sequence s_devNack;
        state_reg == twe_pkg::ST_DEV && byteDone && !devMatch;
    endsequence

    property p_oeOnFall;
        $fell(sdaOeN_reg) |-> $past(sclFall);
    endproperty
    a_oeOnFall: assert property (p_oeOnFall)
        else $error("SDA pulled low outside an SCL fall.");

    property p_neverHigh;
        sdaOut_reg == 1'b0;
    endproperty
    a_neverHigh: assert property (p_neverHigh)
        else $error("SDA output value is not low.");

    property p_ackDrive;
        s_devAck |=> !sdaOeN_reg && state_reg == twe_pkg::ST_ACK;
    endproperty
    a_ackDrive: assert property (p_ackDrive)
        else $error("Matching device byte not acknowledged.");

    property p_nack;
        s_devNack |=> sdaOeN_reg && state_reg == twe_pkg::ST_IDLE;
    endproperty
    a_nack: assert property (p_nack)
        else $error("Wrong device type was acknowledged.");

    property p_deaf;
        state_reg == twe_pkg::ST_PROG |=> sdaOeN_reg;
    endproperty
    a_deaf: assert property (p_deaf)
        else $error("SDA driven while programming.");

    property p_pageWrap;
        dataDone |=> addrCnt_reg[10:4] == $past(addrCnt_reg[10:4])
            && addrCnt_reg[3:0] == $past(addrCnt_reg[3:0]) + 4'h1;
    endproperty
    a_pageWrap: assert property (p_pageWrap)
        else $error("Write address left its page.");

    property p_readInc;
        readLoad |=> addrCnt_reg == $past(addrCnt_reg) + 11'h001;
    endproperty
    a_readInc: assert property (p_readInc)
        else $error("Read address did not advance with wrap.");

    property p_lock;
        stopEv && lockLvl_reg |=> state_reg == twe_pkg::ST_IDLE;
    endproperty
    a_lock: assert property (p_lock)
        else $error("Programming started while locked.");

    property p_start;
        startEv && !progDone |=> state_reg == twe_pkg::ST_DEV
            && bitCnt_reg == 4'h0;
    endproperty
    a_start: assert property (p_start)
        else $error("START did not restart the device byte.");

    property p_progLen;
        progStart |=> (state_reg == twe_pkg::ST_PROG)[*8];
    endproperty
    a_progLen: assert property (p_progLen)
        else $error("Programming ended too early.");
endmodule
`default_nettype wire

/* File: rtl/twe_map.svh */
// Constants and field layout of the two-wire EEPROM slave.
`ifndef TWE_MAP_SVH
`define TWE_MAP_SVH

`define TWE_ADDR_W 11
`define TWE_DEPTH 2048
`define TWE_DEV_TYPE 4'hA
`define TWE_BYTE_BITS 4'h8
`define TWE_CLK_PERIOD_NS 40
`define TWE_PROG_TIME_NS 5000000
`define TWE_PROG_CYCLES (`TWE_PROG_TIME_NS / `TWE_CLK_PERIOD_NS)
`define TWE_TIMER_W 17

`endif

/* File: rtl/twe_pkg.sv */
// Types shared by the two-wire EEPROM slave and its array.
`default_nettype none
package twe_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEV = 3'b001,
        ST_WORD = 3'b010,
        ST_DATA = 3'b011,
        ST_ACK = 3'b100,
        ST_READ = 3'b101,
        ST_MACK = 3'b110,
        ST_PROG = 3'b111
    } twe_state_t;

    typedef struct packed {
        logic en;
        logic [10:0] addr;
        logic [7:0] data;
    } twe_memwr_t;

endpackage
`default_nettype wire

/* File: rtl/twe_mem.sv */
// Byte array of the EEPROM with registered read data.
`timescale 1ns/1ns
`default_nettype none
`include "twe_map.svh"
module twe_mem (
    // Clock
    input wire logic clk_sys,
    // Write port
    input wire twe_pkg::twe_memwr_t memWr,
    // Read port
    input wire logic [10:0] rdAddr,
    output logic [7:0] rdData_reg
);
    logic [7:0] cells [`TWE_DEPTH];

    // The array has no reset, as nonvolatile contents must not be cleared.
    always_ff @(posedge clk_sys) begin
        if (memWr.en) begin
            cells[memWr.addr] <= memWr.data;
        end
    end

    always_ff @(posedge clk_sys) begin
        rdData_reg <= cells[rdAddr];
    end
endmodule
`default_nettype wire

/* File: dv/twe_master_model.sv */
// Behavioural two-wire bus master that talks to the EEPROM slave.
`timescale 1ns/1ns
`default_nettype none
module twe_master_model (
    // Clock
    input wire logic clk_sys,
    // Bus wires
    input wire logic sdaWire,
    output logic sclOut,
    output logic sdaRelease
);
    initial begin
        sclOut = 1'b1;
        sdaRelease = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic waitClk(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // SDA moves only in the middle of the low phase, well clear of the
    // slave's own output change four cycles after the fall.
    task automatic clkBit(input logic v, output logic s);
        waitClk(5);
        sdaRelease = v;
        waitClk(5);
        sclOut = 1'b1;
        waitClk(4);
        s = sdaWire;
        waitClk(4);
        sclOut = 1'b0;
    endtask

    task automatic start();
        waitClk(5);
        sdaRelease = 1'b1;
        waitClk(5);
        sclOut = 1'b1;
        waitClk(8);
        sdaRelease = 1'b0;
        waitClk(8);
        sclOut = 1'b0;
    endtask

    task automatic stop();
        waitClk(5);
        sdaRelease = 1'b0;
        waitClk(5);
        sclOut = 1'b1;
        waitClk(8);
        sdaRelease = 1'b1;
        waitClk(8);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clkBit(b[i], s);
        end
        clkBit(1'b1, s);
        ack = ~s;
    endtask

    task automatic recvByte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clkBit(1'b1, s);
            b[i] = s;
        end
        clkBit(~ack, s);
    endtask
endmodule
`default_nettype wire

/* File: dv/twe_eeprom_slave_tb.sv */
// Self-checking testbench of the two-wire EEPROM slave.
`timescale 1ns/1ns
`default_nettype none
module twe_eeprom_slave_tb;
    // Short programming time keeps the run brief but still outlasts a poll.
    localparam int PROG = 600;
    localparam int LIMIT = 20000;
    logic clk_sys;
    logic rstn;
    logic arrayLockPin;
    logic [2:0] unusedChipSelectPins;
    logic sdaOut;
    logic sdaOeN;
    logic progBusy;
    logic standby;
    logic sclOut;
    logic sdaRelease;
    wire logic sdaWire;
    int n_errors;
    int compares;
    int cycles;
    int k;
    logic [7:0] rd;

    // Wired-AND of the open-drain slave, the master and the pull-up.
    assign sdaWire = (sdaOeN | sdaOut) & sdaRelease;

    twe_eeprom_slave #(.PROG_CYCLES(PROG)) DUT (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .sclPin(sclOut),
        .sdaIn(sdaWire),
        .sdaOut(sdaOut),
        .sdaOeN(sdaOeN),
        .arrayLockPin(arrayLockPin),
        .unusedChipSelectPins(unusedChipSelectPins),
        .progBusy(progBusy),
        .standby(standby)
    );

    twe_master_model mst (
        .clk_sys(clk_sys),
        .sdaWire(sdaWire),
        .sclOut(sclOut),
        .sdaRelease(sdaRelease)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic sendChk(input string name, input logic [7:0] b,
                           input logic exp);
        logic a;
        mst.sendByte(b, a);
        check(name, {15'h0000, a}, {15'h0000, exp});
    endtask

    task automatic recvChk(input string name, input logic ack,
                           input logic [7:0] exp);
        mst.recvByte(ack, rd);
        check(name, {8'h00, rd}, {8'h00, exp});
    endtask

    task automatic setAddr(input logic [7:0] devW, input logic [7:0] word);
        mst.start();
        sendChk("dummy dev ack", devW, 1'b1);
        sendChk("dummy word ack", word, 1'b1);
        mst.start();
        sendChk("read dev ack", 8'hA1, 1'b1);
    endtask

    task automatic writeByte(input logic [7:0] word, input logic [7:0] d);
        mst.start();
        sendChk("write dev ack", 8'hA0, 1'b1);
        sendChk("word ack", word, 1'b1);
        sendChk("data ack", d, 1'b1);
        check("open drain value", {15'h0000, sdaOut}, 16'h0000);
        mst.stop();
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_errors++;
            final_report();
        end
    end

    initial begin
        rstn = 1'b0;
        arrayLockPin = 1'b0;
        unusedChipSelectPins = 3'h5;
        n_errors = 0;
        compares = 0;
        cycles = 0;
        repeat (2) @(negedge clk_sys);
        rstn = 1'b1;
        repeat (6) @(negedge clk_sys);
        // Byte write, then acknowledge polling across the busy time.
        writeByte(8'h00, 8'h5A);
        repeat (4) @(negedge clk_sys);
        check("busy after stop", {15'h0000, progBusy}, 16'h0001);
        mst.start();
        sendChk("poll while busy", 8'hA0, 1'b0);
        mst.stop();
        while (progBusy !== 1'b0) @(negedge clk_sys);
        mst.start();
        sendChk("poll when done", 8'hA0, 1'b1);
        mst.stop();
        // Random read of the written byte, then standby.
        setAddr(8'hA0, 8'h00);
        recvChk("random read", 1'b0, 8'h5A);
        mst.stop();
        repeat (6) @(negedge clk_sys);
        check("standby after read", {15'h0000, standby}, 16'h0001);
        // Full page write that starts two bytes before the page end.
        mst.start();
        sendChk("page dev ack", 8'hAE, 1'b1);
        sendChk("page word ack", 8'hFE, 1'b1);
        for (int i = 0; i < 16; i++) begin
            sendChk("page data ack", 8'h10 + i[7:0], 1'b1);
        end
        fork
            mst.stop();
            begin
                k = 0;
                while (progBusy !== 1'b1) @(negedge clk_sys);
                while (progBusy === 1'b1) begin
                    @(negedge clk_sys);
                    k++;
                end
            end
        join
        check("programming length", 16'(k), 16'(PROG));
        // Sequential read over the page wrap and the array end.
        setAddr(8'hAE, 8'hFD);
        recvChk("seq 7fd", 1'b1, 8'h1F);
        recvChk("seq 7fe", 1'b1, 8'h10);
        recvChk("seq 7ff", 1'b0, 8'h11);
        mst.stop();
        mst.start();
        sendChk("current dev ack", 8'hA1, 1'b1);
        recvChk("wrap to zero", 1'b0, 8'h5A);
        mst.stop();
        // Locked write is acknowledged but leaves the cell alone.
        unusedChipSelectPins = 3'h2;
        arrayLockPin = 1'b1;
        writeByte(8'h00, 8'hC3);
        repeat (6) @(negedge clk_sys);
        check("no busy when locked", {15'h0000, progBusy}, 16'h0000);
        arrayLockPin = 1'b0;
        setAddr(8'hA0, 8'h00);
        recvChk("locked cell kept", 1'b0, 8'h5A);
        mst.stop();
        // Foreign device type is not acknowledged.
        mst.start();
        sendChk("foreign type nack", 8'h50, 1'b0);
        mst.stop();
        repeat (6) @(negedge clk_sys);
        check("standby after foreign", {15'h0000, standby}, 16'h0001);
        final_report();
    end
endmodule
`default_nettype wire
